// *** common/hub_cfg_defines.vh ***
`ifndef HUB_CFG_DEFINES_VH
`define HUB_CFG_DEFINES_VH

// Register offsets on the configuration access port
`define ADDR_PORT_USED_CONFIG 8'h08
`define ADDR_DEVICE_CONFIG_TWO 8'h0a

// device_config_two field positions
`define DC2_RSVD_HI_BIT 7
`define DC2_CHARGE_OVR_BIT 6
`define DC2_POLARITY_BIT 5
`define DC2_HI_SEL_BIT 4
`define DC2_SPARE_HI_BIT 3
`define DC2_SPARE_LO_BIT 2
`define DC2_AUTO_DIS_BIT 1
`define DC2_RSVD_LO_BIT 0

// port_used_config field layout
`define PUC_USED_HI_BIT 3
`define PUC_USED_LO_BIT 0

// Reset values
`define PORT_USED_RESET 4'hf
`define CHARGE_OVR_RESET 1'h0
`define POLARITY_RESET 1'h0
`define HI_SEL_RESET 1'h0
`define SPARE_RESET 2'h0
`define AUTO_DIS_RESET 1'h0
`define READ_DATA_RESET 8'h00
`define UNMAPPED_READ 8'h00

// Per-port charging behaviour codes
`define CHARGE_MODE_WIDTH 3
`define CHARGE_OFF 3'h0
`define CHARGE_CDP 3'h1
`define CHARGE_DCP 3'h2
`define CHARGE_AUTO_PROFILE_TWO 3'h3
`define CHARGE_AUTO_PROFILE_THREE 3'h4

`endif

// *** hw/charge_mode_select.v ***
`timescale 1ns/1ps

`include "hub_cfg_defines.vh"

module charge_mode_select #(
	parameter PORTS = 4
) (
	// Configuration
	input wire autoChargeDisable,
	input wire highCurrentSelect,
	// Port state
	input wire upstreamConnected,
	input wire [PORTS-1:0] chargePortEnable,
	// Result, one code per port
	output reg [PORTS*`CHARGE_MODE_WIDTH-1:0] chargeModeNext
);

	integer i;

	always @* begin
		chargeModeNext = {PORTS*`CHARGE_MODE_WIDTH{1'b0}};
		for (i = 0; i < PORTS; i = i + 1) begin
			if (!chargePortEnable[i]) begin
				chargeModeNext[i*`CHARGE_MODE_WIDTH +: `CHARGE_MODE_WIDTH] = `CHARGE_OFF;
			end else if (upstreamConnected) begin
				// Host attached: always CDP, disable bit ignored
				chargeModeNext[i*`CHARGE_MODE_WIDTH +: `CHARGE_MODE_WIDTH] = `CHARGE_CDP;
			end else if (autoChargeDisable) begin
				chargeModeNext[i*`CHARGE_MODE_WIDTH +: `CHARGE_MODE_WIDTH] = `CHARGE_DCP;
			end else if (highCurrentSelect) begin
				// Divider select matters only in this branch
				chargeModeNext[i*`CHARGE_MODE_WIDTH +: `CHARGE_MODE_WIDTH] = `CHARGE_AUTO_PROFILE_THREE;
			end else begin
				chargeModeNext[i*`CHARGE_MODE_WIDTH +: `CHARGE_MODE_WIDTH] = `CHARGE_AUTO_PROFILE_TWO;
			end
		end
	end

endmodule // charge_mode_select

// *** hw/hub_port_charge_config_regs.v ***
`timescale 1ns/1ps

`include "hub_cfg_defines.vh"

// Contract
// - Four port-used bits, bit n is port n+1
// - Port-used writable only with port override set
// - Legacy-speed-only forces USB2 side enabled
// - Bits 7 and 0 read zero, ignore writes
// - Charge override gates divider select writes
// - Override and divider select written together
// - Power-switch outputs follow polarity bit
// - Auto mode uses profile two or three
// - Divider select reads OTP while override clear
// - Bits 3:2 are plain read-back storage
// - Auto-disable bit captured from strap at reset
// - Disable zero enables auto, one DCP/CDP only
// - Auto only charging ports, upstream unconnected
// - Upstream connected gives CDP on charging ports
// - Divider select affects high-current auto only
// - Port override makes port fields writable
// - Charging-enabled per bit of enable field
module hub_port_charge_config_regs #(
	parameter PORTS = 4
) (
	// Clock and reset
	input wire clock,
	input wire rst,
	input wire clockEnable,
	// Configuration source selection
	input wire smbusMode,
	input wire eepromMode,
	// SMBus host register access
	input wire hostWrite,
	input wire hostRead,
	input wire [7:0] hostAddr,
	input wire [7:0] hostWriteData,
	output reg [7:0] hostReadData,
	// EEPROM loader
	input wire eepromLoad,
	input wire [7:0] eepromAddr,
	input wire [7:0] eepromData,
	// Strap pins
	input wire polarityStrapPin,
	input wire autoChargeStrapPin,
	// OTP defaults
	input wire [PORTS-1:0] otpPortUsed,
	input wire otpHighCurrentSelect,
	// Neighbouring configuration fields
	input wire portConfigOverride,
	input wire [PORTS-1:0] legacySpeedOnly,
	input wire [PORTS-1:0] chargePortEnable,
	// Hub state
	input wire upstreamConnected,
	input wire [PORTS-1:0] portPowerRequest,
	// Port controls
	output reg [PORTS-1:0] portEnable,
	output reg [PORTS-1:0] usb2PortEnable,
	output reg [PORTS-1:0] powerSwitchEnableOut,
	output reg [PORTS*`CHARGE_MODE_WIDTH-1:0] chargeMode,
	// Effective configuration
	output reg powerSwitchPolarity,
	output reg autoChargeDisable,
	output reg highCurrentSelect
);

	// Width of one per-port charging code
	localparam MW = `CHARGE_MODE_WIDTH;

	// Writable bits of device_config_two; bits 7 and 0 are dropped on the way in
	localparam [7:0] DC2_WRITE_MASK = 8'h7e;

	// Stored fields
	reg [PORTS-1:0] portUsed_reg;
	reg [PORTS-1:0] portUsed_next;
	reg chargeOverride_reg;
	reg chargeOverride_next;
	reg polarity_reg;
	reg polarity_next;
	reg hiSel_reg;
	reg hiSel_next;
	reg [1:0] spare_reg;
	reg [1:0] spare_next;
	reg autoDis_reg;
	reg autoDis_next;
	reg strapPending_reg;
	reg [7:0] readData_next;

	// Merged write path
	reg wrEn;
	reg [7:0] wrAddr;
	reg [7:0] wrData;
	wire hostWriteTaken;
	wire eepromWriteTaken;
	wire wrPortUsed;
	wire wrDevCfgTwo;
	wire [PORTS-1:0] usedWriteValue;
	wire [7:0] dc2WriteData;

	// Effective values
	wire [PORTS-1:0] usedEff;
	wire hiSelEff;
	wire [7:0] portUsedRead;
	wire [7:0] devCfgTwoRead;
	wire [PORTS*MW-1:0] chargeModeNext;
	wire [PORTS-1:0] usb2Next;
	wire [PORTS-1:0] switchNext;

	// Source qualifiers; a strobe in the wrong mode never reaches the fields
	assign eepromWriteTaken = eepromMode & eepromLoad;
	assign hostWriteTaken = smbusMode & hostWrite;

	// EEPROM wins if both sources strike at once; in practice only one mode is live
	always @* begin
		wrEn = 1'b0;
		wrAddr = 8'h00;
		wrData = 8'h00;
		if (eepromWriteTaken) begin
			wrEn = 1'b1;
			wrAddr = eepromAddr;
			wrData = eepromData;
		end else if (hostWriteTaken) begin
			wrEn = 1'b1;
			wrAddr = hostAddr;
			wrData = hostWriteData;
		end
	end

	// Address decode and write images
	assign wrPortUsed = wrEn && (wrAddr == `ADDR_PORT_USED_CONFIG);
	assign wrDevCfgTwo = wrEn && (wrAddr == `ADDR_DEVICE_CONFIG_TWO);
	// Upper nibble of a port-used write is dropped, it reads back as zero
	assign usedWriteValue = wrData[`PUC_USED_LO_BIT +: PORTS];
	assign dc2WriteData = wrData & DC2_WRITE_MASK;

	// Effective field values seen by the port logic and by reads
	assign usedEff = portConfigOverride ? portUsed_reg : otpPortUsed;
	assign hiSelEff = chargeOverride_reg ? hiSel_reg : otpHighCurrentSelect;

	// Read images; reserved bits forced low
	// Port-used reads show the OTP image unless the override is set
	assign portUsedRead = {{(8-PORTS){1'b0}}, usedEff};
	assign devCfgTwoRead = {
		1'b0,
		chargeOverride_reg,
		polarity_reg,
		hiSelEff,
		spare_reg,
		autoDis_reg,
		1'b0
	};

	// Port-used field; without the override the OTP image stands
	// The override bit itself lives outside this block
	always @* begin
		portUsed_next = portUsed_reg;
		if (wrPortUsed && portConfigOverride) begin
			portUsed_next = usedWriteValue;
		end
	end

	// Charge override and divider select
	always @* begin
		chargeOverride_next = chargeOverride_reg;
		hiSel_next = hiSel_reg;
		if (wrDevCfgTwo) begin
			chargeOverride_next = dc2WriteData[`DC2_CHARGE_OVR_BIT];
			// Gate on the incoming override so one access can set both
			if (dc2WriteData[`DC2_CHARGE_OVR_BIT]) begin
				hiSel_next = dc2WriteData[`DC2_HI_SEL_BIT];
			end
		end
	end

	// Polarity; the strap capture outranks a write in the same cycle
	always @* begin
		polarity_next = polarity_reg;
		if (strapPending_reg) begin
			polarity_next = polarityStrapPin;
		end else if (wrDevCfgTwo) begin
			polarity_next = dc2WriteData[`DC2_POLARITY_BIT];
		end
	end

	// Spare bits: storage only, read back as written
	// Ignored in the strap cycle, like the other strap-loaded bits
	always @* begin
		spare_next = spare_reg;
		if (!strapPending_reg && wrDevCfgTwo) begin
			spare_next = dc2WriteData[`DC2_SPARE_HI_BIT:`DC2_SPARE_LO_BIT];
		end
	end

	// Auto-charge disable
	always @* begin
		autoDis_next = autoDis_reg;
		if (strapPending_reg) begin
			autoDis_next = autoChargeStrapPin;
		end else if (wrDevCfgTwo) begin
			autoDis_next = dc2WriteData[`DC2_AUTO_DIS_BIT];
		end
	end

	// Read decode; data holds between reads
	always @* begin
		readData_next = hostReadData;
		if (hostRead) begin
			case (hostAddr)
				`ADDR_PORT_USED_CONFIG: begin
					readData_next = portUsedRead;
				end
				`ADDR_DEVICE_CONFIG_TWO: begin
					readData_next = devCfgTwoRead;
				end
				default: begin
					readData_next = `UNMAPPED_READ;
				end
			endcase
		end
	end

	// Port-used storage
	always @(posedge clock) begin
		if (rst) begin
			portUsed_reg <= `PORT_USED_RESET;
		end else if (clockEnable) begin
			portUsed_reg <= portUsed_next;
		end
	end

	// Charge override and divider select storage
	always @(posedge clock) begin
		if (rst) begin
			chargeOverride_reg <= `CHARGE_OVR_RESET;
			hiSel_reg <= `HI_SEL_RESET;
		end else if (clockEnable) begin
			chargeOverride_reg <= chargeOverride_next;
			hiSel_reg <= hiSel_next;
		end
	end

	// Strap-loaded and spare storage; straps are sampled on the first enabled edge after release
	always @(posedge clock) begin
		if (rst) begin
			polarity_reg <= `POLARITY_RESET;
			spare_reg <= `SPARE_RESET;
			autoDis_reg <= `AUTO_DIS_RESET;
			strapPending_reg <= 1'b1;
		end else if (clockEnable) begin
			polarity_reg <= polarity_next;
			spare_reg <= spare_next;
			autoDis_reg <= autoDis_next;
			strapPending_reg <= 1'b0;
		end
	end

	// Read data register
	always @(posedge clock) begin
		if (rst) begin
			hostReadData <= `READ_DATA_RESET;
		end else if (clockEnable) begin
			hostReadData <= readData_next;
		end
	end

	// Effective polarity
	always @(posedge clock) begin
		if (rst) begin
			powerSwitchPolarity <= `POLARITY_RESET;
		end else if (clockEnable) begin
			powerSwitchPolarity <= polarity_reg;
		end
	end

	// Effective auto-charge disable
	always @(posedge clock) begin
		if (rst) begin
			autoChargeDisable <= `AUTO_DIS_RESET;
		end else if (clockEnable) begin
			autoChargeDisable <= autoDis_reg;
		end
	end

	// Divider select as the charging logic sees it
	always @(posedge clock) begin
		if (rst) begin
			highCurrentSelect <= `HI_SEL_RESET;
		end else if (clockEnable) begin
			highCurrentSelect <= hiSelEff;
		end
	end

	// Per-port charging behaviour from the effective configuration
	charge_mode_select #(
		.PORTS(PORTS)
	) i_charge_mode_select (
		.autoChargeDisable(autoDis_reg),
		.highCurrentSelect(hiSelEff),
		.upstreamConnected(upstreamConnected),
		.chargePortEnable(chargePortEnable),
		.chargeModeNext(chargeModeNext)
	);

	// Per-port next values for the enables and the power switch
	genvar n;
	generate
		for (n = 0; n < PORTS; n = n + 1) begin : portNext
			// Legacy-speed-only ports keep their USB2 side on whatever the used bit says
			assign usb2Next[n] = usedEff[n] | legacySpeedOnly[n];
			// Active-low switches invert the request when the polarity bit is clear
			assign switchNext[n] = polarity_reg ? portPowerRequest[n] : ~portPowerRequest[n];
		end
	endgenerate

	// Per-port enables, power-switch drive and charging code
	genvar p;
	generate
		for (p = 0; p < PORTS; p = p + 1) begin : portLogic
			always @(posedge clock) begin
				if (rst) begin
					portEnable[p] <= 1'b0;
					usb2PortEnable[p] <= 1'b0;
					// Reset polarity is active low, so off is high
					powerSwitchEnableOut[p] <= 1'b1;
					chargeMode[p*MW +: MW] <= `CHARGE_OFF;
				end else if (clockEnable) begin
					portEnable[p] <= usedEff[p];
					usb2PortEnable[p] <= usb2Next[p];
					powerSwitchEnableOut[p] <= switchNext[p];
					chargeMode[p*MW +: MW] <= chargeModeNext[p*MW +: MW];
				end
			end
		end
	endgenerate

endmodule // hub_port_charge_config_regs

// *** verification/hub_cfg_properties.sv ***
`timescale 1ns/1ps
`include "hub_cfg_defines.vh"
module hub_cfg_properties #(
	parameter PORTS = 4
) (
	// Clock and reset
	input wire clock,
	input wire rst,
	input wire clockEnable,
	// Inputs watched
	input wire hostRead,
	input wire [7:0] hostAddr,
	input wire polarityStrapPin,
	input wire autoChargeStrapPin,
	input wire upstreamConnected,
	input wire [PORTS-1:0] legacySpeedOnly,
	input wire [PORTS-1:0] chargePortEnable,
	input wire [PORTS-1:0] portPowerRequest,
	// Outputs watched
	input wire [7:0] hostReadData,
	input wire [PORTS-1:0] portEnable,
	input wire [PORTS-1:0] usb2PortEnable,
	input wire [PORTS-1:0] powerSwitchEnableOut,
	input wire [PORTS*`CHARGE_MODE_WIDTH-1:0] chargeMode,
	input wire powerSwitchPolarity,
	input wire autoChargeDisable,
	input wire highCurrentSelect
);
	// High once the previous edge was out of reset with the clock enable set
	reg settled;
	wire [2:0] m0 = chargeMode[2:0];
	always @(posedge clock) begin
		settled <= !rst && clockEnable;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_switch;
		settled |-> powerSwitchEnableOut == (powerSwitchPolarity ? $past(portPowerRequest) : ~$past(portPowerRequest));
	endproperty
	a_switch: assert property (p_switch) else $error("switch level wrong");
	property p_usb2;
		settled |-> usb2PortEnable == (portEnable | $past(legacySpeedOnly));
	endproperty
	a_usb2: assert property (p_usb2) else $error("usb2 enable wrong");
	property p_off;
		settled && !$past(chargePortEnable[0]) |-> m0 == `CHARGE_OFF;
	endproperty
	a_off: assert property (p_off) else $error("uncharged port not off");
	property p_cdp;
		settled && $past(chargePortEnable[0] && upstreamConnected) |-> m0 == `CHARGE_CDP;
	endproperty
	a_cdp: assert property (p_cdp) else $error("cdp missing");
	property p_auto;
		settled && $past(chargePortEnable[0] && !upstreamConnected) && !autoChargeDisable
			|-> m0 == (highCurrentSelect ? `CHARGE_AUTO_PROFILE_THREE : `CHARGE_AUTO_PROFILE_TWO);
	endproperty
	a_auto: assert property (p_auto) else $error("auto profile wrong");
	property p_dcp;
		settled && $past(chargePortEnable[0] && !upstreamConnected) && autoChargeDisable |-> m0 == `CHARGE_DCP;
	endproperty
	a_dcp: assert property (p_dcp) else $error("dcp missing");
	property p_rsvd;
		settled && $past(hostRead) && $past(hostAddr) == `ADDR_DEVICE_CONFIG_TWO |-> hostReadData[7] == 1'b0 && hostReadData[0] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_pol_strap;
		$fell(rst) |-> ##2 powerSwitchPolarity == $past(polarityStrapPin, 2);
	endproperty
	a_pol_strap: assert property (p_pol_strap) else $error("polarity strap lost");
	property p_auto_strap;
		$fell(rst) |-> ##2 autoChargeDisable == $past(autoChargeStrapPin, 2);
	endproperty
	a_auto_strap: assert property (p_auto_strap) else $error("auto strap lost");
	c_two: cover property (settled && m0 == `CHARGE_AUTO_PROFILE_TWO);
	c_cdp: cover property (settled && m0 == `CHARGE_CDP);
	c_read: cover property (settled && $past(hostRead));
endmodule // hub_cfg_properties

// *** verification/eeprom_loader_model.sv ***
`timescale 1ns/1ps
module eeprom_loader_model (
	// Clock and command
	input wire clock,
	input wire start,
	input wire [7:0] addr,
	input wire [7:0] data,
	// Loader side
	output reg eepromLoad,
	output reg [7:0] eepromAddr,
	output reg [7:0] eepromData
);
	initial eepromLoad = 1'b0;
	initial eepromAddr = 8'h00;
	initial eepromData = 8'h00;
	// Idle lines toggle so stale bytes never look valid
	always @(posedge clock) begin
		eepromLoad <= start;
		eepromAddr <= start ? addr : ~eepromAddr;
		eepromData <= start ? data : ~eepromData;
	end
endmodule // eeprom_loader_model

// *** verification/hub_port_charge_config_regs_tb.sv ***
`timescale 1ns/1ps
`include "hub_cfg_defines.vh"
module hub_port_charge_config_regs_tb;
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg clockEnable = 1'b1;
	reg smbusMode = 1'b1;
	reg eepromMode = 1'b0;
	reg hostWrite = 1'b0;
	reg hostRead = 1'b0;
	reg [7:0] hostAddr = 8'h00;
	reg [7:0] hostWriteData = 8'h00;
	reg polarityStrapPin = 1'b1;
	reg autoChargeStrapPin = 1'b1;
	reg [3:0] otpPortUsed = 4'ha;
	reg otpHighCurrentSelect = 1'b1;
	reg portConfigOverride = 1'b0;
	reg [3:0] legacySpeedOnly = 4'h2;
	reg [3:0] chargePortEnable = 4'h1;
	reg upstreamConnected = 1'b0;
	reg [3:0] portPowerRequest = 4'h3;
	reg eeStart = 1'b0;
	reg [7:0] eeAddr = 8'h00;
	reg [7:0] eeData = 8'h00;
	wire eepromLoad;
	wire [7:0] eepromAddr, eepromData, hostReadData;
	wire [3:0] portEnable, usb2PortEnable, powerSwitchEnableOut;
	wire [11:0] chargeMode;
	wire powerSwitchPolarity, autoChargeDisable, highCurrentSelect;
	integer badCount = 0;
	integer samplesChecked = 0;
	integer cycles = 0;
	always #5 clock = ~clock;
	hub_port_charge_config_regs #(.PORTS(4)) i_hub_port_charge_config_regs (.clock(clock), .rst(rst),
		.clockEnable(clockEnable), .smbusMode(smbusMode), .eepromMode(eepromMode), .hostWrite(hostWrite),
		.hostRead(hostRead), .hostAddr(hostAddr), .hostWriteData(hostWriteData), .hostReadData(hostReadData),
		.eepromLoad(eepromLoad), .eepromAddr(eepromAddr), .eepromData(eepromData),
		.polarityStrapPin(polarityStrapPin), .autoChargeStrapPin(autoChargeStrapPin), .otpPortUsed(otpPortUsed),
		.otpHighCurrentSelect(otpHighCurrentSelect), .portConfigOverride(portConfigOverride),
		.legacySpeedOnly(legacySpeedOnly), .chargePortEnable(chargePortEnable),
		.upstreamConnected(upstreamConnected), .portPowerRequest(portPowerRequest), .portEnable(portEnable),
		.usb2PortEnable(usb2PortEnable), .powerSwitchEnableOut(powerSwitchEnableOut), .chargeMode(chargeMode),
		.powerSwitchPolarity(powerSwitchPolarity), .autoChargeDisable(autoChargeDisable),
		.highCurrentSelect(highCurrentSelect));
	eeprom_loader_model i_eeprom_loader_model (.clock(clock), .start(eeStart), .addr(eeAddr), .data(eeData),
		.eepromLoad(eepromLoad), .eepromAddr(eepromAddr), .eepromData(eepromData));
	task chk(input [63:0] name, input [11:0] got, input [11:0] exp);
		begin
			samplesChecked = samplesChecked + 1;
			if (got !== exp) begin
				badCount = badCount + 1;
				$display("BAD %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clock);
			hostWrite <= 1'b1;
			hostAddr <= a;
			hostWriteData <= d;
			@(posedge clock);
			hostWrite <= 1'b0;
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		begin
			@(posedge clock);
			hostRead <= 1'b1;
			hostAddr <= a;
			@(posedge clock);
			hostRead <= 1'b0;
			#1 chk("read", hostReadData, e);
		end
	endtask
	task ld(input [7:0] d, input up, input [2:0] e);
		begin
			eeAddr <= `ADDR_DEVICE_CONFIG_TWO;
			eeData <= d;
			upstreamConnected <= up;
			eeStart <= 1'b1;
			@(posedge clock);
			eeStart <= 1'b0;
			repeat (3) @(posedge clock);
			#1 chk("mode", chargeMode, {9'h000, e});
		end
	endtask
	task testDone;
		begin
			$display("checks %0d bad %0d", samplesChecked, badCount);
			if (badCount == 0 && samplesChecked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// Whole run needs well under a few hundred cycles
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			badCount = badCount + 1;
			testDone;
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rc(8'h0a, 8'h32);
		rc(8'h08, 8'h0a);
		wr(8'h08, 8'hf5);
		rc(8'h08, 8'h0a);
		portConfigOverride <= 1'b1;
		wr(8'h08, 8'hf5);
		rc(8'h08, 8'h05);
		chk("used", portEnable, 4'h5);
		chk("usb2", usb2PortEnable, 4'h7);
		wr(8'h0a, 8'hff);
		rc(8'h0a, 8'h7e);
		chk("switch", powerSwitchEnableOut, 4'h3);
		wr(8'h0a, 8'h0c);
		rc(8'h0a, 8'h1c);
		chk("switch", powerSwitchEnableOut, 4'hc);
		// A write while the clock enable is low must leave every field as it was
		clockEnable <= 1'b0;
		wr(8'h0a, 8'hff);
		clockEnable <= 1'b1;
		rc(8'h0a, 8'h1c);
		chk("switch", powerSwitchEnableOut, 4'hc);
		smbusMode <= 1'b0;
		wr(8'h0a, 8'h62);
		rc(8'h0a, 8'h1c);
		eepromMode <= 1'b1;
		ld(8'h60, 1'b0, `CHARGE_AUTO_PROFILE_TWO);
		chk("pol", powerSwitchPolarity, 1'b1);
		ld(8'h50, 1'b0, `CHARGE_AUTO_PROFILE_THREE);
		ld(8'h50, 1'b1, `CHARGE_CDP);
		ld(8'h42, 1'b0, `CHARGE_DCP);
		rc(8'h0a, 8'h42);
		testDone;
	end
endmodule // hub_port_charge_config_regs_tb
bind hub_port_charge_config_regs hub_cfg_properties #(.PORTS(PORTS)) i_hub_cfg_properties (.clock(clock), .rst(rst),
	.clockEnable(clockEnable), .hostRead(hostRead), .hostAddr(hostAddr), .polarityStrapPin(polarityStrapPin),
	.autoChargeStrapPin(autoChargeStrapPin), .upstreamConnected(upstreamConnected),
	.legacySpeedOnly(legacySpeedOnly), .chargePortEnable(chargePortEnable), .portPowerRequest(portPowerRequest),
	.hostReadData(hostReadData), .portEnable(portEnable), .usb2PortEnable(usb2PortEnable),
	.powerSwitchEnableOut(powerSwitchEnableOut), .chargeMode(chargeMode), .powerSwitchPolarity(powerSwitchPolarity),
	.autoChargeDisable(autoChargeDisable), .highCurrentSelect(highCurrentSelect));
